// [core/hfp_pkg.sv]
// Shared constants and types of the horizontal floating-point add/subtract unit.
package hfp_pkg;
    localparam int OPW = 128;
    localparam int CSW = 16;
    localparam int NFL = 6;
    localparam int SP_EW = 8;
    localparam int SP_MW = 23;
    localparam int DP_EW = 11;
    localparam int DP_MW = 52;
    // Bit positions inside the vector floating-point control and status word.
    localparam int CSR_DENORM_ZERO = 6;
    localparam int CSR_MASK_LSB = 7;
    localparam int CSR_UM = 11;
    localparam int CSR_RC_LSB = 13;
    localparam int CSR_FLUSH_ZERO = 15;
    // Exception flag positions, shared by the flag and mask fields.
    localparam int FLG_IE = 0;
    localparam int FLG_DE = 1;
    localparam int FLG_ZE = 2;
    localparam int FLG_OE = 3;
    localparam int FLG_UE = 4;
    localparam int FLG_PE = 5;
    localparam logic [NFL-1:0] MASK_ALL = 6'h3F;
    localparam logic [1:0] RC_NEAR = 2'h0;
    localparam logic [1:0] RC_DOWN = 2'h1;
    localparam logic [1:0] RC_UP = 2'h2;
    localparam logic [1:0] RC_ZERO = 2'h3;
    // Identification feature word: bit 0 reports this extension.
    localparam int FEATURE_BIT = 0;
    localparam logic [31:0] FEATURE_WORD = 32'h00000001;
    localparam logic [31:0] SP_ONE = 32'h3F800000;
    localparam logic [31:0] SP_TWO = 32'h40000000;
    localparam logic [31:0] SP_INF = 32'h7F800000;
    localparam logic [63:0] DP_ONE = 64'h3FF0000000000000;
    localparam logic [63:0] DP_TWO = 64'h4000000000000000;

    typedef enum logic [1:0] {
        horiz_add_single,
        horiz_sub_single,
        horiz_add_double,
        horiz_sub_double
    } hfp_op_type;

    typedef struct packed {
        logic             valid;
        logic             write;
        logic             fault;
        logic [NFL-1:0]   flags;
        logic [OPW-1:0]   result;
        logic [31:0]      feature;
    } hfp_state_type;
endpackage

// [core/hfp_lane_if.sv]
// Operand and result bundle between the unit and one lane adder.
`timescale 1ns/1ps
interface hfp_lane_if #(parameter int W = 32);
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic         sub;
    logic [1:0]   rc;
    logic         flush_zero;
    logic         denorm_zero;
    logic [W-1:0] r;
    logic [5:0]   flags;
    modport issue (output a, b, sub, rc, flush_zero, denorm_zero, input r, flags);
    modport lane (input a, b, sub, rc, flush_zero, denorm_zero, output r, flags);
endinterface

// [core/hfp_lane_adder.sv]
// One combinational IEEE add/subtract lane with rounding, flags and denormal controls.
`timescale 1ns/1ps
module hfp_lane_adder #(
    parameter int EW = 8,
    parameter int MW = 23
) (
    hfp_lane_if.lane port_if
);
    import hfp_pkg::*;
    localparam int W = 1 + EW + MW;
    localparam int XW = MW + 5;

    logic          sa, sb, sbig, eff_sub, swap, a_nan, b_nan, a_inf, b_inf, snan;
    logic          found, lost, g, rs, inc, inexact, ovf, tiny;
    logic [EW-1:0] ea, eb, ebn, esn, d;
    logic [MW-1:0] fa, fb, fbig, fsml;
    logic [XW-1:0] mbig, msml, mal, sum, norm;
    logic [EW:0]   e, lz, sh;
    logic [MW+1:0] mr;
    logic [W-1:0]  qbit, res;
    logic [5:0]    fl;

    always_comb begin
        {sa, ea, fa} = port_if.a;
        {sb, eb, fb} = port_if.b;
        sb = sb ^ port_if.sub;
        fl = '0;
        qbit = {{(W - MW){1'b0}}, 1'b1, {(MW - 1){1'b0}}};
        // Denormal inputs read as signed zero and raise no denormal flag.
        if (port_if.denorm_zero && ea == '0) fa = '0;
        if (port_if.denorm_zero && eb == '0) fb = '0;
        fl[FLG_DE] = (ea == '0 && fa != '0) || (eb == '0 && fb != '0);
        a_nan = (&ea) && (fa != '0);
        b_nan = (&eb) && (fb != '0);
        a_inf = (&ea) && (fa == '0);
        b_inf = (&eb) && (fb == '0);
        snan = (a_nan && !fa[MW-1]) || (b_nan && !fb[MW-1]);
        swap = {eb, fb} > {ea, fa};
        sbig = swap ? sb : sa;
        eff_sub = sa ^ sb;
        fbig = swap ? fb : fa;
        fsml = swap ? fa : fb;
        // Zero exponent behaves as exponent one with no hidden bit.
        ebn = swap ? eb : ea;
        esn = swap ? ea : eb;
        mbig = {1'b0, ebn != '0, fbig, 3'h0};
        msml = {1'b0, esn != '0, fsml, 3'h0};
        ebn = ebn | {{(EW - 1){1'b0}}, ebn == '0};
        esn = esn | {{(EW - 1){1'b0}}, esn == '0};
        d = ebn - esn;
        mal = msml >> d;
        lost = (mal << d) != msml;
        mal[0] = mal[0] | lost;
        sum = eff_sub ? mbig - mal : mbig + mal;
        e = {1'b0, ebn};
        lz = '0;
        found = 1'b0;
        for (int i = XW - 2; i >= 0; i--) begin
            if (!found) begin
                if (sum[i]) found = 1'b1;
                else lz = lz + 1'b1;
            end
        end
        sh = '0;
        if (sum[XW-1]) begin
            norm = {1'b0, sum[XW-1:2], sum[1] | sum[0]};
            e = e + 1'b1;
        end else begin
            // Left shift stops at the smallest exponent, leaving a denormal.
            sh = (lz < e - 1'b1) ? lz : e - 1'b1;
            norm = sum << sh;
            e = e - sh;
        end
        g = norm[2];
        rs = |norm[1:0];
        inexact = g | rs;
        case (port_if.rc)
            RC_NEAR: inc = g & (rs | norm[3]);
            RC_DOWN: inc = sbig & inexact;
            RC_UP:   inc = ~sbig & inexact;
            default: inc = 1'b0;
        endcase
        mr = {1'b0, norm[XW-2:3]} + {{(MW + 1){1'b0}}, inc};
        if (mr[MW+1]) begin
            mr = mr >> 1;
            e = e + 1'b1;
        end
        ovf = e >= {1'b0, {EW{1'b1}}};
        tiny = !mr[MW];
        // Same rounding and flag behaviour as a vertical add of this precision.
        if (a_nan || b_nan) begin
            fl[FLG_IE] = snan;
            res = a_nan ? (port_if.a | qbit) : (port_if.b | qbit);
        end else if (a_inf || b_inf) begin
            if (a_inf && b_inf && eff_sub) begin
                fl[FLG_IE] = 1'b1;
                res = {1'b1, {EW{1'b1}}, 1'b1, {(MW - 1){1'b0}}};
            end else begin
                res = {a_inf ? sa : sb, {EW{1'b1}}, {MW{1'b0}}};
            end
        end else if (sum == '0) begin
            res = {eff_sub ? (port_if.rc == RC_DOWN) : sa, {(W - 1){1'b0}}};
        end else if (ovf) begin
            fl[FLG_OE] = 1'b1;
            fl[FLG_PE] = 1'b1;
            if (port_if.rc == RC_NEAR || (port_if.rc == RC_UP && !sbig)
                || (port_if.rc == RC_DOWN && sbig)) begin
                res = {sbig, {EW{1'b1}}, {MW{1'b0}}};
            end else begin
                res = {sbig, {(EW - 1){1'b1}}, 1'b0, {MW{1'b1}}};
            end
        end else if (tiny && port_if.flush_zero) begin
            fl[FLG_UE] = 1'b1;
            fl[FLG_PE] = 1'b1;
            res = {sbig, {(W - 1){1'b0}}};
        end else begin
            fl[FLG_PE] = inexact;
            fl[FLG_UE] = tiny & inexact;
            res = {sbig, mr[MW] ? e[EW-1:0] : {EW{1'b0}}, mr[MW-1:0]};
        end
        port_if.r = res;
        port_if.flags = fl;
    end
endmodule

// [core/hfp_unit.sv]
// Horizontal packed floating-point add/subtract unit with one cycle of latency.
`timescale 1ns/1ps
module hfp_unit (
    input  wire logic                          mclk,
    input  wire logic                          resetn,
    input  wire logic                          issue_valid,
    input  wire hfp_pkg::hfp_op_type           issue_op,
    input  wire logic [hfp_pkg::OPW-1:0]       dst_operand,
    input  wire logic [hfp_pkg::OPW-1:0]       src_operand,
    input  wire logic [hfp_pkg::CSW-1:0]       control_status,
    output logic                               result_valid,
    output logic                               result_write,
    output logic [hfp_pkg::OPW-1:0]            result,
    output logic [hfp_pkg::NFL-1:0]            status_flags,
    output logic                               fp_fault,
    output logic [31:0]                        feature_word
);
    import hfp_pkg::*;

    hfp_state_type      state;
    hfp_state_type      next_state;
    logic [2*OPW-1:0]   wide;
    logic               is_sub;
    logic               is_double;
    logic [1:0]         rc;
    logic [NFL-1:0]     masks;
    logic               flush_eff;
    logic [31:0]        s_res [4];
    logic [NFL-1:0]     s_fl [4];
    logic [63:0]        d_res [2];
    logic [NFL-1:0]     d_fl [2];
    logic [NFL-1:0]     fl;

    // The source sits above the destination so lane k pairs elements 2k and 2k+1.
    assign wide = {src_operand, dst_operand};
    assign is_sub = issue_op == horiz_sub_single || issue_op == horiz_sub_double;
    assign is_double = issue_op == horiz_add_double || issue_op == horiz_sub_double;
    assign rc = control_status[CSR_RC_LSB +: 2];
    assign masks = control_status[CSR_MASK_LSB +: NFL];
    // Flushing is only legal while underflow is masked.
    assign flush_eff = control_status[CSR_FLUSH_ZERO] & control_status[CSR_UM];

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_single
            hfp_lane_if #(.W(32)) sif ();
            // Lower element is the minuend, as the subtract order demands.
            assign sif.a = wide[64*i +: 32];
            assign sif.b = wide[64*i+32 +: 32];
            assign sif.sub = is_sub;
            assign sif.rc = rc;
            assign sif.flush_zero = flush_eff;
            assign sif.denorm_zero = control_status[CSR_DENORM_ZERO];
            assign s_res[i] = sif.r;
            assign s_fl[i] = sif.flags;
            hfp_lane_adder #(.EW(SP_EW), .MW(SP_MW)) u_lane (.port_if(sif.lane));
        end
        for (i = 0; i < 2; i++) begin : g_double
            hfp_lane_if #(.W(64)) dif ();
            assign dif.a = wide[128*i +: 64];
            assign dif.b = wide[128*i+64 +: 64];
            assign dif.sub = is_sub;
            assign dif.rc = rc;
            assign dif.flush_zero = flush_eff;
            assign dif.denorm_zero = control_status[CSR_DENORM_ZERO];
            assign d_res[i] = dif.r;
            assign d_fl[i] = dif.flags;
            hfp_lane_adder #(.EW(DP_EW), .MW(DP_MW)) u_lane (.port_if(dif.lane));
        end
    endgenerate

    always_comb begin
        next_state = state;
        next_state.valid = 1'b0;
        next_state.fault = 1'b0;
        next_state.write = 1'b0;
        fl = is_double ? (d_fl[0] | d_fl[1]) : (s_fl[0] | s_fl[1] | s_fl[2] | s_fl[3]);
        if (issue_valid) begin
            next_state.valid = 1'b1;
            next_state.flags = fl;
            // An unmasked exception leaves the destination untouched.
            next_state.fault = |(fl & ~masks);
            next_state.write = ~|(fl & ~masks);
            if (|(fl & ~masks)) begin
                next_state.result = dst_operand;
            end else if (is_double) begin
                next_state.result = {d_res[1], d_res[0]};
            end else begin
                next_state.result = {s_res[3], s_res[2], s_res[1], s_res[0]};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state <= '{valid: 1'b0, write: 1'b0, fault: 1'b0, flags: '0, result: '0,
                       feature: FEATURE_WORD};
        end else begin
            state <= next_state;
        end
    end

    assign result_valid = state.valid;
    assign result_write = state.write;
    assign result = state.result;
    assign status_flags = state.flags;
    assign fp_fault = state.fault;
    assign feature_word = state.feature;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_issue_latency: assert property (issue_valid |=> result_valid)
        else $error("result did not follow issue by one cycle");
    a_src_pair_lane: assert property (issue_valid && issue_op == horiz_add_single
        && src_operand[31:0] == SP_ONE && src_operand[63:32] == SP_ONE && masks == MASK_ALL
        |=> result[95:64] == SP_TWO) else $error("lane 2 not taken from source pair");
    a_add_single_lane: assert property (issue_valid && issue_op == horiz_add_single
        && dst_operand[31:0] == SP_ONE && dst_operand[63:32] == SP_ONE && masks == MASK_ALL
        |=> result[31:0] == SP_TWO) else $error("single add lane 0 wrong");
    a_sub_single_zero: assert property (issue_valid && issue_op == horiz_sub_single
        && dst_operand[31:0] == dst_operand[63:32] && masks == MASK_ALL
        && dst_operand[30:23] != 8'hFF && rc != RC_DOWN
        |=> result[31:0] == 32'h00000000) else $error("single sub of equals not +0");
    a_add_double_lane: assert property (issue_valid && issue_op == horiz_add_double
        && dst_operand[63:0] == DP_ONE && dst_operand[127:64] == DP_ONE && masks == MASK_ALL
        |=> result[63:0] == DP_TWO) else $error("double add lane 0 wrong");
    a_sub_double_zero: assert property (issue_valid && issue_op == horiz_sub_double
        && src_operand[63:0] == src_operand[127:64] && masks == MASK_ALL
        && src_operand[62:52] != 11'h7FF && rc != RC_DOWN
        |=> result[127:64] == 64'h0000000000000000) else $error("double sub lane 1 not +0");
    a_feature_bit: assert property (##1 feature_word[FEATURE_BIT])
        else $error("feature bit not reported");
    a_daz_input: assert property (issue_valid && issue_op == horiz_add_single
        && control_status[CSR_DENORM_ZERO] && dst_operand[31:23] == 9'h000 && masks == MASK_ALL
        && dst_operand[22:0] != 23'h000000 && dst_operand[63:32] == 32'h00000000
        |=> result_valid && result[31:0] == 32'h00000000 && !status_flags[FLG_DE])
        else $error("denormal input not read as zero");
    a_fault_masks: assert property (issue_valid ##1 result_valid
        |-> fp_fault == |(status_flags & ~$past(masks)) && result_write == !fp_fault)
        else $error("fault does not match masks");
    a_inf_invalid: assert property (issue_valid && issue_op == horiz_sub_single
        && dst_operand[31:0] == SP_INF && dst_operand[63:32] == SP_INF
        |=> status_flags[FLG_IE]) else $error("inf minus inf not invalid");

    c_add_single: cover property (issue_valid && issue_op == horiz_add_single ##1 result_write);
    c_sub_double: cover property (issue_valid && issue_op == horiz_sub_double ##1 result_write);
    c_fault: cover property (fp_fault);
    c_back_to_back: cover property (issue_valid [*2] ##1 result_valid);
endmodule

// [tb/hfp_issue_model.sv]
// Issue-side model: presents requests to the unit and collects its answers.
`timescale 1ns/1ps
module hfp_issue_model (
    input  wire logic                    mclk,
    output logic                         issue_valid,
    output hfp_pkg::hfp_op_type          issue_op,
    output logic [hfp_pkg::OPW-1:0]      dst_operand,
    output logic [hfp_pkg::OPW-1:0]      src_operand,
    output logic [hfp_pkg::CSW-1:0]      control_status,
    input  wire logic                    result_valid,
    input  wire logic                    result_write,
    input  wire logic [hfp_pkg::OPW-1:0] result,
    input  wire logic [hfp_pkg::NFL-1:0] status_flags,
    input  wire logic                    fp_fault
);
    import hfp_pkg::*;
    logic [135:0] resp_q[$];
    initial begin
        issue_valid = 1'b0;
        issue_op = horiz_add_single;
        dst_operand = '0;
        src_operand = '0;
        control_status = '0;
    end
    // Called just after a rising edge; the request is taken at the next edge.
    task automatic issue(input hfp_op_type op, input logic [OPW-1:0] d, s,
                         input logic [CSW-1:0] cs);
        issue_valid <= 1'b1;
        issue_op <= op;
        dst_operand <= d;
        src_operand <= s;
        control_status <= cs;
        @(posedge mclk);
    endtask
    // Released operands are inverted once per call, so sampling without a request shows.
    task automatic idle();
        issue_valid <= 1'b0;
        dst_operand <= ~dst_operand;
        src_operand <= ~src_operand;
        control_status <= ~control_status;
        @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        if (result_valid === 1'b1) begin
            resp_q.push_back({result_write, fp_fault, status_flags, result});
        end
    end
endmodule

// [tb/tb_top.sv]
// Self-checking bench of the horizontal add/subtract unit.
`timescale 1ns/1ps
module tb_top;
    import hfp_pkg::*;
    logic           mclk, resetn, issue_valid, result_valid, result_write, fp_fault;
    hfp_op_type     issue_op;
    logic [OPW-1:0] dst_operand, src_operand, result;
    logic [CSW-1:0] control_status;
    logic [NFL-1:0] status_flags;
    logic [31:0]    feature_word;
    logic [135:0]   exp_q[$];
    int             err_total = 0;
    int             tests_run = 0;

    hfp_unit u_hfp_unit (.mclk(mclk), .resetn(resetn), .issue_valid(issue_valid),
        .issue_op(issue_op), .dst_operand(dst_operand), .src_operand(src_operand),
        .control_status(control_status), .result_valid(result_valid),
        .result_write(result_write), .result(result), .status_flags(status_flags),
        .fp_fault(fp_fault), .feature_word(feature_word));
    hfp_issue_model u_hfp_issue_model (.mclk(mclk), .issue_valid(issue_valid),
        .issue_op(issue_op), .dst_operand(dst_operand), .src_operand(src_operand),
        .control_status(control_status), .result_valid(result_valid),
        .result_write(result_write), .result(result), .status_flags(status_flags),
        .fp_fault(fp_fault));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Small integers only, so every lane sum is exact in either precision.
    function automatic logic [31:0] sp(input int v);
        logic [63:0] d;
        logic [10:0] e;
        d = $realtobits(real'(v));
        e = d[62:52] - 11'h380;
        if (v == 0) return 32'h00000000;
        return {d[63], e[7:0], d[51:29]};
    endfunction
    function automatic logic [63:0] dp(input int v);
        return (v == 0) ? 64'h0 : $realtobits(real'(v));
    endfunction
    function automatic logic [OPW-1:0] pk(input hfp_op_type op, input int a[4]);
        if (op inside {horiz_add_double, horiz_sub_double}) return {dp(a[1]), dp(a[0])};
        return {sp(a[3]), sp(a[2]), sp(a[1]), sp(a[0])};
    endfunction
    function automatic logic [OPW-1:0] hexp(input hfp_op_type op, input int a[4], b[4]);
        int r[4];
        logic sub;
        sub = op inside {horiz_sub_single, horiz_sub_double};
        for (int i = 0; i < 2; i++) begin
            r[i] = sub ? a[2*i] - a[2*i+1] : a[2*i] + a[2*i+1];
            r[i+2] = sub ? b[2*i] - b[2*i+1] : b[2*i] + b[2*i+1];
        end
        if (op inside {horiz_add_double, horiz_sub_double}) return {dp(r[2]), dp(r[0])};
        return {sp(r[3]), sp(r[2]), sp(r[1]), sp(r[0])};
    endfunction
    function automatic logic [CSW-1:0] cw(input logic fz, input logic [1:0] rc,
                                          input logic [5:0] mask, input logic dz);
        return {fz, rc, mask, dz, 6'h00};
    endfunction

    task automatic cmp(input string what, input logic [135:0] e, g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    // A fault keeps the destination and suppresses the write-back.
    task automatic send(input hfp_op_type op, input logic [OPW-1:0] d, s,
                        input logic [CSW-1:0] cs, input logic [OPW-1:0] r,
                        input logic [NFL-1:0] fl);
        logic flt;
        flt = |(fl & ~cs[CSR_MASK_LSB +: NFL]);
        exp_q.push_back({!flt, flt, fl, flt ? d : r});
        u_hfp_issue_model.issue(op, d, s, cs);
    endtask
    task automatic drain(input string name);
        logic [135:0] e, g;
        u_hfp_issue_model.idle();
        for (int i = 0; i < 8 && u_hfp_issue_model.resp_q.size() < exp_q.size(); i++)
            @(posedge mclk);
        cmp("answers", 136'(exp_q.size()), 136'(u_hfp_issue_model.resp_q.size()));
        while (exp_q.size() > 0 && u_hfp_issue_model.resp_q.size() > 0) begin
            e = exp_q.pop_front();
            g = u_hfp_issue_model.resp_q.pop_front();
            cmp("result", 136'(e[127:0]), 136'(g[127:0]));
            cmp("flags", 136'(e[133:128]), 136'(g[133:128]));
            cmp("fault and write", 136'(e[135:134]), 136'(g[135:134]));
        end
        exp_q.delete();
        u_hfp_issue_model.resp_q.delete();
        $display("test %s done", name);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        report_and_stop();
    end

    initial begin
        int a[4], b[4];
        int rnd;
        hfp_op_type op;
        logic [1:0] rc;
        resetn = 1'b0;
        rnd = $urandom(24775);
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        #1;
        cmp("reset outputs", 136'({result_valid, result_write | fp_fault, status_flags,
            result}), 136'(0));
        cmp("feature word", 136'(FEATURE_WORD), 136'(feature_word));
        @(posedge mclk);
        // Bursts of back-to-back requests; round-down is left out because an
        // exact zero of differing signs would then be negative.
        for (int n = 0; n < 40; n++) begin
            for (int i = 0; i < 4; i++) begin
                a[i] = int'($urandom_range(2000)) - 1000;
                b[i] = int'($urandom_range(2000)) - 1000;
            end
            op = hfp_op_type'($urandom_range(3));
            rc = 2'($urandom_range(3));
            if (rc == RC_DOWN) rc = RC_NEAR;
            send(op, pk(op, a), pk(op, b), cw(1'($urandom_range(1)), rc, MASK_ALL,
                 1'($urandom_range(1))) | 16'($urandom_range(63)), hexp(op, a, b), 6'h00);
            if (n % 8 == 7) drain("random burst");
        end
        // A reset in mid-run must clear the answer path again.
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        #1;
        cmp("mid-run reset", 136'({result_valid, result_write | fp_fault, status_flags,
            result}), 136'(0));
        @(posedge mclk);
        a = '{1, 1, 1, 1};
        for (int k = 0; k < 4; k++) begin
            op = hfp_op_type'(k);
            send(op, pk(op, a), pk(op, a), cw(0, RC_NEAR, MASK_ALL, 0),
                 hexp(op, a, a), 6'h00);
        end
        send(horiz_sub_single, {64'h0, SP_INF, SP_INF}, '0, cw(0, RC_NEAR, MASK_ALL, 0),
             {96'h0, 32'hFFC00000}, 6'h01);
        send(horiz_sub_single, {64'h0, SP_INF, SP_INF}, '0, cw(0, RC_NEAR, 6'h3E, 0),
             '0, 6'h01);
        for (int m = 0; m < 4; m++)
            send(horiz_add_single, {64'h0, 32'h33800000, SP_ONE}, '0,
                 cw(0, 2'(m), MASK_ALL, 0), {96'h0, (2'(m) == RC_UP) ? 32'h3F800001 : SP_ONE},
                 6'h20);
        send(horiz_add_single, {64'h0, 32'h33800000, SP_ONE}, '0, cw(0, RC_NEAR, 6'h1F, 0),
             '0, 6'h20);
        send(horiz_add_single, 128'h1, '0, cw(0, RC_NEAR, MASK_ALL, 0), 128'h1, 6'h02);
        send(horiz_add_single, 128'h1, '0, cw(0, RC_NEAR, MASK_ALL, 1), '0, 6'h00);
        send(horiz_sub_single, {64'h0, 64'h0080000000800001}, '0,
             cw(0, RC_NEAR, MASK_ALL, 0), 128'h1, 6'h00);
        send(horiz_sub_single, {64'h0, 64'h0080000000800001}, '0,
             cw(1, RC_NEAR, MASK_ALL, 0), '0, 6'h30);
        send(horiz_sub_double, {2{64'h7FF0000000000000}}, {64'h7FF0000000000000, 64'h0},
             cw(0, RC_NEAR, MASK_ALL, 0), {64'hFFF0000000000000, 64'hFFF8000000000000},
             6'h01);
        drain("corners");
        report_and_stop();
    end
endmodule
